// ---- pkg/pps_pkg.sv ----
// constants, enumerations and behaviour notes for the port power sequencer
// ==========================================================================
// Notes on behaviour
// [RL1] midspan strap: wait 3.2 s after each failed detection unless open circuit
// [RL2] classify right after good detection, applying about 18V, measuring current
// [RL3] decode class current bands into class 0..4 and store the class
// [RL4] class 4 handled like class 0 for allocation and overload threshold
// [RL5] enforce input: 100mA class 1, 175mA class 2, else 375mA threshold
// [RL6] during classification keep port low impedance, limit current to 60mA
// [RL7] after classification compare budget node with 1V; continue only below
// [RL8] source budget current by class: 72.3uA, 32.8uA class 2, 18.8uA class 1
// [RL9] allocation current set by pulse width modulation, averaged by capacitor
// [RL10] after adding allocation recheck node; power port only if still below 1V
// [RL11] recheck above 1V: withdraw current, abort, return to detection
// [RL12] powered: turn off when current above threshold longer than 62ms
// [RL13] one limit for inrush and short; shut off after limit active 62ms
// [RL14] full current limit above 30V port voltage, foldback limit below
// [RL15] outside midspan backoff, repeat detection every 580ms until valid device
// [RL16] after overload trip wait four seconds; timer clears if overload ends
// [RL17] shutdown low turns port off, halts all; after release wait 4 s
// [RL18] comparator inputs sampled synchronously; all delays from counters
// [RL19] hold class and allocation while powered; release both at turn off
// ==========================================================================
package pps_pkg;
  // ========================================================================
  // timing
  localparam longint CLK_HZ = 200000000;
  localparam longint MIDSPAN_MS = 3200;
  localparam longint DETECT_PERIOD_MS = 580;
  localparam longint RESTART_MS = 4000;
  localparam longint OVERLOAD_MS = 62;
  localparam longint MS_CYCLES = CLK_HZ / 1000;
  localparam int MIDSPAN_CYC = int'(MIDSPAN_MS * MS_CYCLES);
  localparam int DETECT_PERIOD_CYC = int'(DETECT_PERIOD_MS * MS_CYCLES);
  localparam int RESTART_CYC = int'(RESTART_MS * MS_CYCLES);
  localparam int OVERLOAD_CYC = int'(OVERLOAD_MS * MS_CYCLES);
  localparam int CNT_W = 32;
  // ========================================================================
  // class codes and overload threshold selects
  localparam logic [2:0] CLASS_0 = 3'h0;
  localparam logic [2:0] CLASS_1 = 3'h1;
  localparam logic [2:0] CLASS_2 = 3'h2;
  localparam logic [2:0] CLASS_3 = 3'h3;
  localparam logic [2:0] CLASS_4 = 3'h4;
  localparam logic [2:0] CLASS_RESET = 3'h0;
  // overload threshold select: 0 = 375mA, 1 = 100mA, 2 = 175mA
  localparam logic [1:0] THR_375MA = 2'h0;
  localparam logic [1:0] THR_100MA = 2'h1;
  localparam logic [1:0] THR_175MA = 2'h2;
  // pwm duty in 1/256 of full-scale 72.3uA
  localparam int PWM_W = 8;
  localparam logic [PWM_W-1:0] DUTY_FULL = 8'hff; // 72.3uA
  localparam logic [PWM_W-1:0] DUTY_C2 = 8'h73; // ~32.8uA
  localparam logic [PWM_W-1:0] DUTY_C1 = 8'h42; // ~18.8uA
  localparam int SETTLE_CYC = 1024; // budget node settling after alloc
  localparam int CLASSIFY_CYC = 2048; // classification measurement window
  // ========================================================================
  typedef enum logic [3:0] {
    ST_HOLD, ST_WAIT, ST_DETECT, ST_CLASSIFY, ST_BUDGET, ST_ALLOC,
    ST_RECHECK, ST_POWERED
  } pps_state_type;
endpackage

// ---- logic/pps_pwm.sv ----
// pulse width modulator for the budget node allocation current
`timescale 1ns/10ps
module pps_pwm
  import pps_pkg::*;
#(
  parameter int W = PWM_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] duty,
  output logic pwm_out
);
  logic [W-1:0] phase_q;
  // free running phase counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_q + 1'b1;
    end
  end
  // registered compare keeps the pin glitch free
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= (duty == '1) ? 1'b1 : (phase_q < duty); // [RL9]
    end
  end
endmodule // pps_pwm

// ---- logic/pps_port_sequencer.sv ----
// port power sequencer top: detection timing, class, budget, power control
`timescale 1ns/10ps
module pps_port_sequencer
  import pps_pkg::*;
#(
  parameter int MIDSPAN_CYCLES = MIDSPAN_CYC,
  parameter int DETECT_PERIOD_CYCLES = DETECT_PERIOD_CYC,
  parameter int RESTART_CYCLES = RESTART_CYC,
  parameter int OVERLOAD_CYCLES = OVERLOAD_CYC,
  parameter int CLASSIFY_CYCLES = CLASSIFY_CYC,
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic SHUTDOWN_N,
  input wire logic MIDSPAN_MODE,
  input wire logic ENFORCE_CLASS_LIMIT,
  input wire logic DETECT_DONE,
  input wire logic DETECT_VALID,
  input wire logic DETECT_OPEN,
  input wire logic [2:0] CLASS_BAND,
  input wire logic BUDGET_ABOVE_1V,
  input wire logic OVER_THRESHOLD,
  input wire logic LIMIT_ACTIVE,
  input wire logic PORT_ABOVE_30V,
  output logic DETECT_START,
  output logic CLASSIFY_ENABLE,
  output logic CLASS_CURRENT_LIMIT_60MA,
  output logic [2:0] PORT_CLASS,
  output logic [1:0] OVERLOAD_CURRENT_THRESHOLD,
  output logic POWER_BUDGET_NODE_PWM,
  output logic PORT_POWER_ON,
  output logic FOLDBACK_ACTIVE,
  output logic OVERLOAD_TRIP
);
  // ========================================================================
  // input synchronisers: every pin passes two flops
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  assign pin_raw = {SHUTDOWN_N, MIDSPAN_MODE, ENFORCE_CLASS_LIMIT,
                    DETECT_DONE, DETECT_VALID, DETECT_OPEN, CLASS_BAND,
                    BUDGET_ABOVE_1V, OVER_THRESHOLD, LIMIT_ACTIVE};
  // shutdown synchroniser resets to low so we start halted
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_raw; // [RL18]
      sync2_q <= sync1_q;
    end
  end
  logic v30_s1_q;
  logic v30_s2_q;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      v30_s1_q <= 1'b0;
      v30_s2_q <= 1'b0;
    end else begin
      v30_s1_q <= PORT_ABOVE_30V;
      v30_s2_q <= v30_s1_q;
    end
  end
  logic sd_n;
  logic midspan;
  logic enforce;
  logic det_done;
  logic det_valid;
  logic det_open;
  logic [2:0] band;
  logic budget_high;
  logic over_thr;
  logic lim_act;
  assign sd_n = sync2_q[11];
  assign midspan = sync2_q[10];
  assign enforce = sync2_q[9];
  assign det_done = sync2_q[8];
  assign det_valid = sync2_q[7];
  assign det_open = sync2_q[6];
  assign band = sync2_q[5:3];
  assign budget_high = sync2_q[2];
  assign over_thr = sync2_q[1];
  assign lim_act = sync2_q[0];
  // ========================================================================
  // sequencer state and shared delay counter
  pps_state_type state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] ovl_q;
  logic [CNT_W-1:0] lim_q;
  logic [2:0] class_q;
  logic [PWM_W-1:0] duty_q;
  logic ovl_exp;
  logic lim_exp;
  assign ovl_exp = (ovl_q >= CNT_W'(OVERLOAD_CYCLES));
  assign lim_exp = (lim_q >= CNT_W'(OVERLOAD_CYCLES));
  // main sequence; shutdown wins over every state
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= ST_HOLD;
      cnt_q <= '0;
    end else if (!sd_n) begin
      state_q <= ST_HOLD; // [RL17]
      cnt_q <= '0;
    end else begin
      case (state_q)
        ST_HOLD: begin
          // released: restart delay before first detection
          state_q <= ST_WAIT; // [RL17]
          cnt_q <= CNT_W'(RESTART_CYCLES);
        end
        ST_WAIT: begin
          if (cnt_q <= CNT_W'(1)) begin
            state_q <= ST_DETECT;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1); // [RL18]
          end
        end
        ST_DETECT: begin
          if (det_done) begin
            if (det_valid) begin
              state_q <= ST_CLASSIFY; // [RL2]
              cnt_q <= CNT_W'(CLASSIFY_CYCLES);
            end else if (midspan && !det_open) begin
              state_q <= ST_WAIT; // [RL1]
              cnt_q <= CNT_W'(MIDSPAN_CYCLES);
            end else begin
              state_q <= ST_WAIT; // [RL15]
              cnt_q <= CNT_W'(DETECT_PERIOD_CYCLES);
            end
          end
        end
        ST_CLASSIFY: begin
          if (cnt_q <= CNT_W'(1)) begin
            state_q <= ST_BUDGET;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        ST_BUDGET: begin
          if (budget_high) begin
            state_q <= ST_WAIT; // [RL7]
            cnt_q <= CNT_W'(DETECT_PERIOD_CYCLES);
          end else begin
            state_q <= ST_ALLOC;
            cnt_q <= CNT_W'(SETTLE_CYCLES);
          end
        end
        ST_ALLOC: begin
          // let the filter capacitor settle with our current added
          if (cnt_q <= CNT_W'(1)) begin
            state_q <= ST_RECHECK;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        ST_RECHECK: begin
          if (budget_high) begin
            state_q <= ST_WAIT; // [RL11] one-count wait re-pulses detect start
            cnt_q <= CNT_W'(1);
          end else begin
            state_q <= ST_POWERED; // [RL10]
          end
        end
        ST_POWERED: begin
          if (ovl_exp || lim_exp) begin
            state_q <= ST_WAIT; // [RL12] [RL13] [RL16]
            cnt_q <= CNT_W'(RESTART_CYCLES);
          end
        end
        default: begin
          state_q <= ST_HOLD;
          cnt_q <= '0;
        end
      endcase
    end
  end
  // ========================================================================
  // overload and current limit timers, cleared when condition ends
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ovl_q <= '0;
    end else if (state_q != ST_POWERED || !over_thr || !sd_n) begin
      ovl_q <= '0; // [RL16]
    end else if (!ovl_exp) begin
      ovl_q <= ovl_q + CNT_W'(1); // [RL12]
    end
  end
  // one limit timer covers both inrush and short circuit
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      lim_q <= '0;
    end else if (state_q != ST_POWERED || !lim_act || !sd_n) begin
      lim_q <= '0;
    end else if (!lim_exp) begin
      lim_q <= lim_q + CNT_W'(1); // [RL13]
    end
  end
  // ========================================================================
  // class capture; class 4 is stored as class 4, bands above class 4 read as class 0
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      class_q <= CLASS_RESET;
    end else if (state_q == ST_CLASSIFY && cnt_q <= CNT_W'(1)) begin
      if (band > CLASS_4) begin
        class_q <= CLASS_0; // out of band reads as class 0
      end else begin
        class_q <= band; // [RL3]
      end
    end else if (state_q == ST_WAIT || state_q == ST_HOLD ||
                 state_q == ST_DETECT) begin
      class_q <= CLASS_RESET; // [RL19]
    end
  end
  // allocation duty only while allocating, rechecking or powered
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      duty_q <= '0;
    end else if (sd_n && state_q == ST_BUDGET && !budget_high) begin
      case (class_q)
        CLASS_1: duty_q <= DUTY_C1; // [RL8]
        CLASS_2: duty_q <= DUTY_C2;
        default: duty_q <= DUTY_FULL; // [RL4]
      endcase
    end else if (!sd_n || (state_q == ST_RECHECK && budget_high) ||
                 !(state_q == ST_ALLOC || state_q == ST_RECHECK ||
                   state_q == ST_POWERED)) begin
      duty_q <= '0; // [RL11] [RL19]
    end
  end
  pps_pwm #(
    .W(PWM_W)
  ) u_pwm (
    .clk(CLK),
    .nrst(NRST),
    .duty(duty_q),
    .pwm_out(POWER_BUDGET_NODE_PWM)
  );
  // ========================================================================
  // registered outputs
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      OVERLOAD_CURRENT_THRESHOLD <= THR_375MA;
    end else if (enforce && class_q == CLASS_1) begin
      OVERLOAD_CURRENT_THRESHOLD <= THR_100MA; // [RL5]
    end else if (enforce && class_q == CLASS_2) begin
      OVERLOAD_CURRENT_THRESHOLD <= THR_175MA;
    end else begin
      OVERLOAD_CURRENT_THRESHOLD <= THR_375MA; // [RL4]
    end
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PORT_POWER_ON <= 1'b0;
      CLASSIFY_ENABLE <= 1'b0;
      CLASS_CURRENT_LIMIT_60MA <= 1'b0;
      DETECT_START <= 1'b0;
      FOLDBACK_ACTIVE <= 1'b0;
      OVERLOAD_TRIP <= 1'b0;
      PORT_CLASS <= CLASS_RESET;
    end else begin
      // port drops the same edge the trip or shutdown is seen
      PORT_POWER_ON <= sd_n && state_q == ST_POWERED && !ovl_exp &&
                       !lim_exp;
      CLASSIFY_ENABLE <= sd_n && state_q == ST_CLASSIFY; // [RL2]
      CLASS_CURRENT_LIMIT_60MA <= sd_n && state_q == ST_CLASSIFY; // [RL6]
      DETECT_START <= sd_n && state_q == ST_WAIT && cnt_q <= CNT_W'(1);
      FOLDBACK_ACTIVE <= sd_n && state_q == ST_POWERED && !v30_s2_q; // [RL14]
      OVERLOAD_TRIP <= sd_n && state_q == ST_POWERED && (ovl_exp || lim_exp);
      PORT_CLASS <= class_q;
    end
  end
endmodule // pps_port_sequencer

// ---- testbench/pps_port_sequencer_chk.sv ----
// checker: port sequencer output relations
`timescale 1ns/10ps
module pps_port_sequencer_chk
  import pps_pkg::*;
#(
  parameter int OVERLOAD_CYCLES = OVERLOAD_CYC
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic SHUTDOWN_N,
  input wire logic ENFORCE_CLASS_LIMIT,
  input wire logic BUDGET_ABOVE_1V,
  input wire logic OVER_THRESHOLD,
  input wire logic LIMIT_ACTIVE,
  input wire logic PORT_ABOVE_30V,
  input wire logic DETECT_START,
  input wire logic CLASSIFY_ENABLE,
  input wire logic CLASS_CURRENT_LIMIT_60MA,
  input wire logic [2:0] PORT_CLASS,
  input wire logic [1:0] OVERLOAD_CURRENT_THRESHOLD,
  input wire logic POWER_BUDGET_NODE_PWM,
  input wire logic PORT_POWER_ON,
  input wire logic FOLDBACK_ACTIVE,
  input wire logic OVERLOAD_TRIP
);
  int ovl_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // ========================================
  // overload run length, seen from the pins
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) ovl_q <= 0;
    else if (OVER_THRESHOLD || LIMIT_ACTIVE) ovl_q <= ovl_q + 1;
    else ovl_q <= 0;
  end
  a_class_limit: assert property (
    CLASSIFY_ENABLE |-> CLASS_CURRENT_LIMIT_60MA && !PORT_POWER_ON)
    else $error("classify limit off");
  a_thr_reduced: assert property (
    PORT_POWER_ON && ENFORCE_CLASS_LIMIT && PORT_CLASS inside {1, 2}
    |-> OVERLOAD_CURRENT_THRESHOLD == PORT_CLASS[1:0])
    else $error("reduced threshold wrong");
  a_thr_full: assert property (
    PORT_POWER_ON && !(ENFORCE_CLASS_LIMIT && PORT_CLASS inside {1, 2})
    |-> OVERLOAD_CURRENT_THRESHOLD == THR_375MA) else $error("not 375mA");
  a_budget_block: assert property (
    BUDGET_ABOVE_1V [*8] |-> !$rose(PORT_POWER_ON))
    else $error("powered over budget");
  a_trip_early: assert property (
    OVERLOAD_TRIP |-> ovl_q >= OVERLOAD_CYCLES) else $error("early trip");
  a_trip_late: assert property (
    ovl_q > OVERLOAD_CYCLES + 6 |-> !PORT_POWER_ON) else $error("late trip");
  a_fold_low: assert property (
    (PORT_POWER_ON && !PORT_ABOVE_30V) [*4] |-> FOLDBACK_ACTIVE)
    else $error("no foldback");
  a_shut_idle: assert property (
    !SHUTDOWN_N [*4] |-> !PORT_POWER_ON && !DETECT_START && !CLASSIFY_ENABLE)
    else $error("active in shutdown");
  a_alloc_free: assert property (
    $fell(PORT_POWER_ON) |-> ##[0:2] !POWER_BUDGET_NODE_PWM && PORT_CLASS == 0)
    else $error("allocation held");
endmodule // pps_port_sequencer_chk

// ---- testbench/pps_pd_model.sv ----
// powered device model: signature, class current, port voltage
`timescale 1ns/10ps
module pps_pd_model (
  input wire logic clk,
  input wire logic start,
  input wire logic cls_en,
  input wire logic pwr_on,
  input wire logic sig_ok,
  input wire logic sig_open,
  input wire logic [2:0] cls,
  input wire logic sag,
  output logic done,
  output logic valid,
  output logic open_ckt,
  output logic [2:0] band,
  output logic above_30v
);
  int cnt_q = 0;
  int up_q = 0;
  // ========================================
  // answer 2 cycles after start, hold 5 cycles so the sync sees it
  always_ff @(posedge clk) begin
    if (start) cnt_q <= 7;
    else if (cnt_q > 0) cnt_q <= cnt_q - 1;
    up_q <= pwr_on ? up_q + 1 : 0;
  end
  // outside the answer window the lines carry the inverse, not a stale value
  assign done = cnt_q inside {[1:5]};
  assign valid = done ? sig_ok : !sig_ok;
  assign open_ckt = done ? sig_open : !sig_open;
  assign band = cls_en ? cls : ~cls;
  // inrush: port voltage passes 30V a few cycles after turn-on
  assign above_30v = up_q > 3 && !sag;
endmodule // pps_pd_model

// ---- testbench/test_pps_port_sequencer.sv ----
// testbench: port sequencer against the powered device model
`timescale 1ns/10ps
module test_pps_port_sequencer;
  localparam int OVL = 50;
  logic clk, nrst, sd_n, mid, enf, ok, opn, bud, ovt, lim, sag;
  logic [2:0] cls, band, pcls;
  logic [1:0] thr;
  logic done, vld, opc, a30, dst, cen, c60, pwm, on, fold, trip;
  int error_cnt = 0;
  int total_checks = 0;
  int n, p, d;
  // enforce, class, threshold code, pwm duty
  logic [19:0] rows [8] = '{20'h000ff, 20'h11142, 20'h12273, 20'h130ff,
    20'h140ff, 20'h01042, 20'h02073, 20'h100ff};
  pps_port_sequencer #(.MIDSPAN_CYCLES(300), .DETECT_PERIOD_CYCLES(100),
    .RESTART_CYCLES(200), .OVERLOAD_CYCLES(OVL), .CLASSIFY_CYCLES(16),
    .SETTLE_CYCLES(16)) i_pps_port_sequencer (.CLK(clk), .NRST(nrst),
    .SHUTDOWN_N(sd_n), .MIDSPAN_MODE(mid), .ENFORCE_CLASS_LIMIT(enf),
    .DETECT_DONE(done), .DETECT_VALID(vld), .DETECT_OPEN(opc),
    .CLASS_BAND(band), .BUDGET_ABOVE_1V(bud), .OVER_THRESHOLD(ovt),
    .LIMIT_ACTIVE(lim), .PORT_ABOVE_30V(a30), .DETECT_START(dst),
    .CLASSIFY_ENABLE(cen), .CLASS_CURRENT_LIMIT_60MA(c60), .PORT_CLASS(pcls),
    .OVERLOAD_CURRENT_THRESHOLD(thr), .POWER_BUDGET_NODE_PWM(pwm),
    .PORT_POWER_ON(on), .FOLDBACK_ACTIVE(fold), .OVERLOAD_TRIP(trip));
  pps_pd_model i_pps_pd_model (.clk(clk), .start(dst), .cls_en(cen),
    .pwr_on(on), .sig_ok(ok), .sig_open(opn), .cls(cls), .sag(sag),
    .done(done), .valid(vld), .open_ckt(opc), .band(band), .above_30v(a30));
  // ========================================
  // shared tasks
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_start(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (!dst && c < 1000);
  endtask
  task automatic wait_on();
    int c;
    c = 0;
    while (!on && c < 2000) begin
      @(negedge clk);
      c++;
    end
    check(9'(on), 9'h1);
  endtask
  task automatic off();
    sd_n = 0;
    repeat (6) @(negedge clk);
    check(9'({on, pwm, pcls}), 9'h0);
    sd_n = 1;
  endtask
  // clock and watchdog; the run needs well under 10000 cycles
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  // main sequence: class table, then overload, budget and backoff cases
  initial begin
    {nrst, mid, enf, opn, cls, bud, ovt, lim, sag} = '0;
    sd_n = 1;
    ok = 1;
    repeat (10) @(negedge clk);
    check(9'({on, dst, pcls}), 9'h0);
    repeat (10) @(negedge clk);
    nrst = 1;
    foreach (rows[i]) begin
      enf = rows[i][16];
      cls = rows[i][14:12];
      wait_on();
      check(9'(pcls), 9'(rows[i][14:12]));
      check(9'(thr), 9'(rows[i][9:8]));
      p = 0;
      repeat (256) begin
        @(negedge clk);
        p += pwm;
      end
      d = rows[i][7:0];
      check(9'(p >= d && p <= d + 1), 9'h1);
      off();
    end
    for (int k = 0; k < 2; k++) begin
      wait_on();
      {ovt, lim} = k ? 2'b01 : 2'b10;
      repeat (OVL / 2) @(negedge clk);
      {ovt, lim} = 2'b00;
      sag = 1;
      repeat (8) @(negedge clk);
      check(9'({on, fold}), 9'h3);
      sag = 0;
      repeat (8) @(negedge clk);
      check(9'(fold), 9'h0);
      {ovt, lim} = k ? 2'b01 : 2'b10;
      n = 0;
      while (on && n < 200) begin
        @(negedge clk);
        n++;
      end
      check(9'(n >= OVL && n <= OVL + 8), 9'h1);
      check(9'(trip), 9'h1);
      {ovt, lim} = 2'b00;
      wait_start(n);
      check(9'(n >= 190), 9'h1);
    end
    bud = 1;
    wait_start(n);
    check(9'(n >= 100 && n < 160 && !on), 9'h1);
    bud = 0;
    n = 0;
    while (!pwm && n < 300) begin
      @(negedge clk);
      n++;
    end
    bud = 1;
    wait_start(n);
    check(9'(n >= 10 && n < 24), 9'h1);
    repeat (4) @(negedge clk);
    check(9'({pwm, on}), 9'h0);
    off();
    ok = 0;
    bud = 0;
    wait_start(n);
    check(9'(n >= 200 && n < 215), 9'h1);
    for (int k = 0; k < 3; k++) begin
      opn = k == 1;
      mid = k != 2;
      wait_start(n);
      p = k ? 100 : 300;
      check(9'(n >= p && n < p + 30), 9'h1);
    end
    end_of_test();
  end
endmodule // test_pps_port_sequencer
bind pps_port_sequencer pps_port_sequencer_chk #(
  .OVERLOAD_CYCLES(OVERLOAD_CYCLES)) i_pps_port_sequencer_chk (.*);
